// file: bench/periph_model.sv
// peripheral-side model driving output slots
`timescale 1ns/1ps
`default_nettype none
module periph_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// peripheral slots
	output logic [29:0] periph_out,
	output logic [29:0] periph_out_enable
);
	logic phase;
	assign periph_out_enable = crossbar_pkg::OUTPUT_SLOTS;
	assign periph_out = {15{phase, ~phase}};
	always_ff @(posedge clock or posedge rst) begin
		if (rst) phase <= 1'b0;
		else phase <= ~phase;
	end
endmodule : periph_model
`default_nettype wire

// file: bench/priority_pin_crossbar_sva.sv
// assertions on the pin crossbar ports
`timescale 1ns/1ps
`default_nettype none
module priority_pin_crossbar_sva #(
	parameter int PINS = 32,
	parameter int SIGNALS = 30
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// watched ports
	input wire crossbar_pkg::route_config_type route_config,
	input wire crossbar_pkg::port_access_type port_access,
	input wire logic [7:0] port_read_data,
	input wire logic [SIGNALS-1:0] periph_out,
	input wire logic [SIGNALS-1:0] periph_out_enable,
	input wire logic [SIGNALS-1:0] periph_in,
	input wire logic [SIGNALS-1:0] signal_routed,
	input wire logic [PINS-1:0] pin_in,
	input wire logic [PINS-1:0] pin_out,
	input wire logic [PINS-1:0] pin_oe_n,
	input wire logic [PINS-1:0] pin_claimed
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	wire logic en = route_config.cfg2[crossbar_pkg::R2_GLOBAL_BIT];
	wire logic uart = route_config.cfg0[crossbar_pkg::R0_FIRST_SERIAL_BIT];
	logic [7:0] pin_byte;
	assign pin_byte = pin_in[port_access.port*8 +: 8];
	sequence s_plain_read;
		!port_access.rmw_read;
	endsequence
	a_plain_read: assert property (s_plain_read |=> port_read_data == $past(pin_byte))
		else $error("read data differs from pin level");
	a_drivers_held: assert property (!en |-> &pin_oe_n)
		else $error("driver on while routing disabled");
	a_nothing_routed: assert property (!en |-> signal_routed == '0 && pin_claimed == '0)
		else $error("routing active while disabled");
	a_serial_first: assert property (en && uart |-> pin_claimed[1:0] == 2'h3)
		else $error("first serial pins not claimed");
	a_uart_unrouted: assert property (!uart |-> signal_routed[1:0] == 2'h0)
		else $error("disabled serial port routed");
	a_pair_together: assert property (signal_routed[0] == signal_routed[1])
		else $error("serial signals split");
	a_input_undriven: assert property (en && uart |-> pin_oe_n[1])
		else $error("receive pin driven");
	a_stray_input: assert property ((periph_in & ~signal_routed) == '0)
		else $error("unrouted slot sees a pin");
	a_periph_drives: assert property (en && uart |-> pin_out[0] == periph_out[0])
		else $error("transmit pin not from peripheral");
endmodule : priority_pin_crossbar_sva
bind priority_pin_crossbar priority_pin_crossbar_sva #(.PINS(PINS), .SIGNALS(SIGNALS)) u_sva (.*);
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the pin crossbar
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	crossbar_pkg::route_config_type cfg = '0;
	logic tw = 1'b0;
	logic [31:0] ana = '0;
	crossbar_pkg::port_access_type acc = '0;
	logic [31:0] pins = '0;
	logic [7:0] rdata;
	logic [29:0] p_out, p_oe, p_in, routed;
	logic [31:0] pout, oe_n, claimed;
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;
	initial forever #20 clock = ~clock;
	periph_model u_model (.clock(clock), .rst(rst), .periph_out(p_out), .periph_out_enable(p_oe));
	priority_pin_crossbar u_dut (.clock(clock), .rst(rst), .route_config(cfg),
		.spi_three_wire(tw), .pin_analog(ana), .port_access(acc), .port_read_data(rdata),
		.periph_out(p_out), .periph_out_enable(p_oe), .periph_in(p_in),
		.signal_routed(routed), .pin_in(pins), .pin_out(pout), .pin_oe_n(oe_n),
		.pin_claimed(claimed));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stop_test
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic set(input logic [31:0] c, input logic [31:0] a, input logic t);
		@(posedge clock);
		cfg <= c;
		ana <= a;
		tw <= t;
		@(posedge clock);
		#1;
	endtask : set
	task automatic wr(input logic b, input logic [1:0] p, input logic [2:0] i, input logic [7:0] d);
		@(posedge clock);
		acc <= '{b, ~b, p, i, d, 1'b0};
		@(posedge clock);
		acc <= '0;
		#1;
	endtask : wr
	task automatic rd(input logic [1:0] p, input logic m, input logic [7:0] exp);
		@(posedge clock);
		acc <= '{1'b0, 1'b0, p, 3'h0, 8'h00, m};
		@(posedge clock);
		#1;
		check(rdata, exp);
	endtask : rd
	task automatic t_off;
		set(32'h07000000, 32'h00000000, 1'b0);
		check(oe_n, 32'hFFFFFFFF);
		check(claimed, 32'h00000000);
	endtask : t_off
	task automatic t_serial;
		set(32'h06001000, 32'h00000000, 1'b0);
		check(claimed, 32'h3F);
		set(32'h06001000, 32'h00000000, 1'b1);
		check(routed, 30'h1F);
		set(32'h02001000, 32'h00000000, 1'b0);
		check(routed, 30'h3C);
	endtask : t_serial
	task automatic t_skip;
		set(32'hF4001000, 32'h00000004, 1'b0);
		check(claimed, 32'h7FB);
		set(32'hF77F1D0B, 32'hFFFF0000, 1'b0);
		check(routed, 30'h3FFFF);
	endtask : t_skip
	task automatic t_gpio;
		set(32'h04001000, 32'h00000000, 1'b0);
		wr(1'b1, 2'h0, 3'h0, 8'h00);
		check(oe_n[7:1], 7'h01);
		check(pout[0], p_out[0]);
		@(posedge clock);
		#1;
		check(pout[0], p_out[0]);
		wr(1'b0, 2'h0, 3'h2, 8'h01);
		check(oe_n[2], 1'b1);
	endtask : t_gpio
	task automatic t_read;
		@(posedge clock);
		pins <= 32'h3CC35A00;
		wr(1'b1, 2'h1, 3'h0, 8'h96);
		rd(2'h1, 1'b0, 8'h5A);
		rd(2'h1, 1'b1, 8'h96);
		rd(2'h2, 1'b0, 8'hC3);
		@(posedge clock);
		pins <= 32'h00000002;
		@(posedge clock);
		#1;
		check(p_in, 30'h00000002);
	endtask : t_read
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		t_off();
		t_serial();
		t_skip();
		t_gpio();
		t_read();
		stop_test();
	end
endmodule : tb
`default_nettype wire

// file: hdl/crossbar_pkg.sv
// package: crossbar constants and carrier types
package crossbar_pkg;
	localparam int PIN_COUNT = 32;
	localparam int SIGNAL_COUNT = 30;
	// route_config_0 bit positions
	localparam int R0_SMB_BIT = 0;
	localparam int R0_SPI_BIT = 1;
	localparam int R0_FIRST_SERIAL_BIT = 2;
	localparam int R0_PCA_LSB = 3;
	localparam int R0_ECI_BIT = 6;
	localparam int R0_CP0_BIT = 7;
	// route_config_1 bit positions
	localparam int R1_CP1_BIT = 0;
	localparam int R1_T0_BIT = 1;
	localparam int R1_INT0_BIT = 2;
	localparam int R1_T1_BIT = 3;
	localparam int R1_INT1_BIT = 4;
	localparam int R1_T2_BIT = 5;
	localparam int R1_T2EX_BIT = 6;
	localparam int R1_SYSCK_BIT = 7;
	// route_config_2 bit positions
	localparam int R2_CNV0_BIT = 0;
	localparam int R2_UART1_BIT = 2;
	localparam int R2_T4_BIT = 3;
	localparam int R2_GLOBAL_BIT = 4;
	// route_config_3 bit positions
	localparam int R3_T3_BIT = 0;
	localparam int R3_T3EX_BIT = 1;
	localparam int R3_CNV2_BIT = 2;
	localparam int R3_CP2_BIT = 3;
	// analog pins that are never skipped (port 2 pins 0 and 1)
	localparam int NOSKIP_PIN_A = 16;
	localparam int NOSKIP_PIN_B = 17;
	// reset values
	localparam logic [7:0] ROUTE_RESET = 8'h00;
	localparam logic [31:0] PORT_DATA_RESET = 32'hFFFFFFFF;
	// signal slots in priority order, highest first
	localparam int S_FIRST_SERIAL_TRANSMIT = 0;
	localparam int S_FIRST_SERIAL_RECEIVE = 1;
	localparam int S_SCK = 2;
	localparam int S_MISO = 3;
	localparam int S_MOSI = 4;
	localparam int S_NSS = 5;
	localparam int S_SDA = 6;
	localparam int S_SCL = 7;
	localparam int S_TX1 = 8;
	localparam int S_RX1 = 9;
	localparam int S_CEX0 = 10;
	localparam int S_ECI = 16;
	localparam int S_CNV0 = 29;
	// slots that are inputs to the peripherals (driver off)
	localparam logic [29:0] INPUT_SLOTS = 30'h3FF10222;
	// slots that carry peripheral outputs
	localparam logic [29:0] OUTPUT_SLOTS = 30'h000EFDDD;

	typedef struct packed {
		logic [7:0] cfg0;
		logic [7:0] cfg1;
		logic [7:0] cfg2;
		logic [7:0] cfg3;
	} route_config_type;

	typedef struct packed {
		logic write_byte;
		logic write_bit;
		logic [1:0] port;
		logic [2:0] bit_index;
		logic [7:0] write_data;
		logic rmw_read;
	} port_access_type;
endpackage : crossbar_pkg

// file: hdl/priority_pin_crossbar.sv
// module: priority crossbar routing peripheral signals onto four 8-bit ports
// Notes on behaviour
// - a peripheral is routed only when its routing enable bits are one
// - first serial port enabled takes transmit and receive on the first two non-analog pins, pin 0 and pin 1 when neither is analog
// - first serial port has top priority and is never displaced
// - disabled peripheral has no signal on any pin
// - serial peripherals request all their signals together; a group gets only a subset when pins run out part-way through it
// - pinout is a pure function of the enabled peripheral set, the SPI three-wire mode and the analog pin configuration
// - unallocated pins are general-purpose I/O via port data bits
// - port data is written as whole bytes or single bits
// - allocated pin is driven by its peripheral; data writes do not affect it
// - normal port read returns the sampled pin level
// - read-modify-write read returns stored port data instead
// - global route enable activates routing
// - global enable low forces all output drivers off
// - pins carrying peripheral inputs have drivers off
// - allocation walks pins from port 0 pin 0 to port 3 pin 7
// - fixed priority from first serial transmit down to converter start zero
// - analog pins are skipped except port 2 pins 0 and 1
`timescale 1ns/1ps
`default_nettype none
module priority_pin_crossbar #(
	parameter int PINS = 32,
	parameter int SIGNALS = 30
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// routing configuration
	input wire crossbar_pkg::route_config_type route_config,
	input wire logic spi_three_wire,
	// analog pin configuration, one per pin (1 = analog)
	input wire logic [PINS-1:0] pin_analog,
	// processor port access
	input wire crossbar_pkg::port_access_type port_access,
	output logic [7:0] port_read_data,
	// peripheral signals, slot order = priority order
	input wire logic [SIGNALS-1:0] periph_out,
	input wire logic [SIGNALS-1:0] periph_out_enable,
	output logic [SIGNALS-1:0] periph_in,
	output logic [SIGNALS-1:0] signal_routed,
	// port pins
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe_n,
	output logic [PINS-1:0] pin_claimed
);
	logic [PINS-1:0] port_data;
	logic [SIGNALS-1:0] want;
	logic [7:0] c0;
	logic [7:0] c1;
	logic [7:0] c2;
	logic [7:0] c3;
	logic global_route_enable;
	logic first_serial_route_enable;
	logic [4:0] slot_pin [SIGNALS];
	logic [SIGNALS-1:0] slot_ok;
	logic [PINS-1:0] owned;
	logic [4:0] pin_slot [PINS];
	logic [PINS-1:0] pin_skip;
	logic [SIGNALS-1:0] slot_drives;
	logic [4:0] bit_pos;
	logic [7:0] pin_byte;
	logic [7:0] data_byte;

	assign c0 = route_config.cfg0;
	assign c1 = route_config.cfg1;
	assign c2 = route_config.cfg2;
	assign c3 = route_config.cfg3;
	assign global_route_enable = c2[crossbar_pkg::R2_GLOBAL_BIT];
	assign first_serial_route_enable = c0[crossbar_pkg::R0_FIRST_SERIAL_BIT];

	assign bit_pos = {port_access.port, port_access.bit_index};
	// only output-type slots may switch a driver on
	assign slot_drives = crossbar_pkg::OUTPUT_SLOTS & ~crossbar_pkg::INPUT_SLOTS
		& periph_out_enable;
	// pins a peripheral holds while routing is on
	assign pin_claimed = owned & {PINS{global_route_enable}};

	// per-slot request from enable bits
	always_comb begin
		want = '0;
		// whole serial groups together
		want[1:0] = {2{first_serial_route_enable}};
		want[4:2] = {3{c0[crossbar_pkg::R0_SPI_BIT]}};
		want[5] = c0[crossbar_pkg::R0_SPI_BIT] & ~spi_three_wire;
		want[7:6] = {2{c0[crossbar_pkg::R0_SMB_BIT]}};
		want[9:8] = {2{c2[crossbar_pkg::R2_UART1_BIT]}};
		// counter array modules: count field selects how many
		for (int k = 0; k < 6; k++) begin
			want[crossbar_pkg::S_CEX0 + k] = (int'(c0[crossbar_pkg::R0_PCA_LSB +: 3]) > k);
		end
		want[16] = c0[crossbar_pkg::R0_ECI_BIT];
		want[17] = c0[crossbar_pkg::R0_CP0_BIT];
		want[18] = c1[crossbar_pkg::R1_CP1_BIT];
		want[19] = c3[crossbar_pkg::R3_CP2_BIT];
		want[20] = c1[crossbar_pkg::R1_T0_BIT];
		want[21] = c1[crossbar_pkg::R1_INT0_BIT];
		want[22] = c1[crossbar_pkg::R1_T1_BIT];
		want[23] = c1[crossbar_pkg::R1_INT1_BIT];
		want[24] = c1[crossbar_pkg::R1_T2_BIT];
		want[25] = c1[crossbar_pkg::R1_T2EX_BIT];
		want[26] = c3[crossbar_pkg::R3_T3_BIT];
		want[27] = c3[crossbar_pkg::R3_T3EX_BIT];
		want[28] = c2[crossbar_pkg::R2_T4_BIT];
		want[29] = c2[crossbar_pkg::R2_CNV0_BIT];
		// clock out and converter two enable bits are not decoded
		// and get no slot in the priority order
	end

	// analog pins drop out of allocation, port 2 pins 0 and 1 excepted
	always_comb begin
		for (int q = 0; q < PINS; q++) begin
			pin_skip[q] = pin_analog[q];
		end
		pin_skip[crossbar_pkg::NOSKIP_PIN_A] = 1'b0;
		pin_skip[crossbar_pkg::NOSKIP_PIN_B] = 1'b0;
	end

	// sequential pin allocation in priority order
	always_comb begin
		int next_pin;
		int p;
		next_pin = 0;
		p = 0;
		slot_ok = '0;
		for (int s = 0; s < SIGNALS; s++) begin
			slot_pin[s] = '0;
		end
		for (int s = 0; s < SIGNALS; s++) begin
			// advance past analog pins
			for (p = 0; p < PINS; p++) begin
				if (next_pin < PINS && pin_skip[next_pin]) begin
					next_pin = next_pin + 1;
				end
			end
			if (want[s] && next_pin < PINS) begin
				slot_ok[s] = 1'b1;
				slot_pin[s] = 5'(next_pin);
				next_pin = next_pin + 1;
			end
		end
	end

	// invert allocation into per-pin ownership
	always_comb begin
		owned = '0;
		for (int q = 0; q < PINS; q++) begin
			pin_slot[q] = '0;
		end
		for (int s = 0; s < SIGNALS; s++) begin
			if (slot_ok[s]) begin
				owned[slot_pin[s]] = 1'b1;
				pin_slot[slot_pin[s]] = 5'(s);
			end
		end
	end

	// port data register, byte or bit writes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			port_data <= crossbar_pkg::PORT_DATA_RESET;
		end else if (port_access.write_byte) begin
			port_data[{port_access.port, 3'b000} +: 8] <= port_access.write_data;
		end else if (port_access.write_bit) begin
			port_data[bit_pos] <= port_access.write_data[0];
		end
	end

	// addressed port byte: pin levels and stored data
	always_comb begin
		pin_byte = pin_in[{port_access.port, 3'b000} +: 8];
		data_byte = port_data[{port_access.port, 3'b000} +: 8];
	end

	// read path: pin level or stored data
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			port_read_data <= 8'h00;
		end else if (port_access.rmw_read) begin
			port_read_data <= data_byte;
		end else begin
			port_read_data <= pin_byte;
		end
	end

	// pin drivers; open-drain data: a 1 releases the pin
	always_comb begin
		logic [4:0] s;
		logic drive;
		logic value;
		s = '0;
		drive = 1'b0;
		value = 1'b1;
		for (int q = 0; q < PINS; q++) begin
			s = pin_slot[q];
			if (owned[q] && global_route_enable) begin
				// peripheral controls the pin
				value = periph_out[s];
				drive = slot_drives[s];
			end else begin
				// general-purpose pin
				value = port_data[q];
				drive = ~port_data[q];
			end
			pin_out[q] = value;
			pin_oe_n[q] = ~(drive & global_route_enable);
		end
	end

	// routed inputs back to peripherals
	always_comb begin
		for (int s = 0; s < SIGNALS; s++) begin
			periph_in[s] = slot_ok[s] & global_route_enable & pin_in[slot_pin[s]];
			signal_routed[s] = slot_ok[s] & global_route_enable;
		end
	end
endmodule : priority_pin_crossbar
`default_nettype wire
